// *** rtl/flash_ctl_pkg.sv ***
// Purpose: Shared constants and types of the parallel flash command controller.
// Assumes: A 250 MHz hclk and a 16-bit asynchronous NOR flash with 21 word address bits.
// Notes: Register offsets are byte addresses on the AHB-Lite slave.
package flash_ctl_pkg;
  // Clock period and flash bus timing.
  localparam int CLK_NS = 4;
  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] T_SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] T_WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] T_HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] T_ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  // Power-on programming lockout after the flash reset is released.
  localparam int POR_TIMEOUT_MS = 10;
  localparam int POR_CYCLES_DFLT = POR_TIMEOUT_MS * 1000000 / CLK_NS;
  localparam int POR_W = 24;

  // Register offsets.
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // Status fields.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_OTP_LOCKED = 3;
  localparam int ST_LOCK_LO = 4;
  // Pin control fields and reset value.
  localparam int PIN_WP = 0;
  localparam int PIN_VPP = 1;
  localparam int PIN_RST = 2;
  localparam logic [2:0] PINS_RST_VAL = 3'h0;

  // Flash command codes and fixed operands.
  localparam logic [15:0] FC_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] FC_CLEAR_STATUS = 16'h0050;
  localparam logic [15:0] FC_ERASE_SETUP = 16'h0020;
  localparam logic [15:0] FC_CONFIRM = 16'h00D0;
  localparam logic [15:0] FC_PROGRAM = 16'h0040;
  localparam logic [15:0] FC_SUSPEND = 16'h00B0;
  localparam logic [15:0] FC_ID_ENTRY = 16'h0090;
  localparam logic [15:0] FC_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] FC_SOFTLOCK = 16'h0001;
  localparam logic [15:0] FC_HARDLOCK = 16'h002F;
  localparam logic [15:0] FC_READ_STATUS = 16'h0070;
  localparam logic [15:0] FC_PROT_SETUP = 16'h00C0;
  localparam logic [15:0] FC_PROT_LOCK_DATA = 16'hFFFD;
  localparam logic [15:0] FC_CFI = 16'h0098;
  localparam logic [20:0] PROT_LOCK_ADDR = 21'h000080;
  localparam logic [20:0] LOCK_STATUS_OFS = 21'h000002;
  localparam int OTP_LOCK_BIT = 1;

  // Operations that software starts through the command register.
  typedef enum logic [3:0] {
    OP_READ, OP_CLEAR, OP_ERASE, OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_ID_ENTRY,
    OP_SOFTLOCK, OP_HARDLOCK, OP_UNLOCK, OP_READ_STATUS, OP_PROT_PROGRAM,
    OP_PROT_LOCK, OP_PROT_QUERY, OP_CFI, OP_LOCK_QUERY
  } op_t;

  typedef enum logic [1:0] {K_END, K_WRITE, K_READ} kind_t;
  typedef enum logic [1:0] {A_USER, A_PROT, A_LOCK} asel_t;
  typedef struct packed {
    kind_t kind;
    asel_t asel;
    logic [15:0] data;
  } step_t;
endpackage : flash_ctl_pkg

// *** rtl/flash_bus_if.sv ***
// Purpose: Carries one flash bus cycle request from the sequencer to the cycle engine.
// Assumes: One request at a time; req is a one-cycle pulse taken only when idle.
// Notes: ack is a one-cycle pulse; rdata is valid with it.
`timescale 1ns/10ps
interface flash_bus_if;
  logic req;
  logic wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport sequencer (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : flash_bus_if

// *** rtl/flash_cycle_engine.sv ***
// Purpose: Runs single write or read bus cycles on the flash pins.
// Assumes: Flash data pins are asynchronous to hclk.
// Notes: Output enable stays high for the whole write cycle.
`timescale 1ns/10ps
module flash_cycle_engine (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request side
  flash_bus_if.engine bus,
  // Flash pins
  output logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_READ} eng_state_t;
  eng_state_t state_ff;
  logic [7:0] cnt_ff;
  logic [15:0] dq_meta_ff;
  logic [15:0] dq_sync_ff;
  logic [15:0] rdata_ff;
  logic ack_ff;
  logic last;

  assign last = (cnt_ff == 8'h01);
  assign bus.ack = ack_ff;
  assign bus.rdata = rdata_ff;

  // Two-stage synchroniser on the data pins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dq_meta_ff <= 16'h0000;
      dq_sync_ff <= 16'h0000;
    end
    else
    begin
      dq_meta_ff <= flash_dq_i;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= E_IDLE;
      cnt_ff <= 8'h00;
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      flash_addr <= 21'h000000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end
    else
    begin
      ack_ff <= 1'b0;
      if (state_ff != E_IDLE)
        cnt_ff <= cnt_ff - 8'h01;
      unique case (state_ff)
        E_IDLE:
          if (bus.req)
          begin
            flash_addr <= bus.addr;
            flash_dq_o <= bus.wdata;
            flash_dq_oe <= bus.wr;
            flash_ce_n <= 1'b0;
            flash_oe_n <= bus.wr; // [RULE20]
            cnt_ff <= bus.wr ? flash_ctl_pkg::T_SETUP_CYC : flash_ctl_pkg::T_ACC_CYC;
            state_ff <= bus.wr ? E_SETUP : E_READ;
          end
        E_SETUP:
          if (last)
          begin
            flash_we_n <= 1'b0; // [RULE20]
            cnt_ff <= flash_ctl_pkg::T_WP_CYC;
            state_ff <= E_STROBE;
          end
        E_STROBE:
          if (last)
          begin
            flash_we_n <= 1'b1;
            cnt_ff <= flash_ctl_pkg::T_HOLD_CYC;
            state_ff <= E_HOLD;
          end
        E_HOLD:
          if (last)
          begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            ack_ff <= 1'b1;
            state_ff <= E_IDLE;
          end
        E_READ:
          if (last)
          begin
            rdata_ff <= dq_sync_ff;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            ack_ff <= 1'b1;
            state_ff <= E_IDLE;
          end
        default:
          state_ff <= E_IDLE;
      endcase
    end
  end
endmodule : flash_cycle_engine

// *** rtl/flash_cmd_ctl.sv ***
// Purpose: AHB-Lite controlled command sequencer for an asynchronous NOR flash.
// Assumes: Single-word AHB-Lite transfers; the slave never inserts wait states.
// Notes: Software loads address and data, then writes an operation code to start it.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
// Contract
// RULE1 - Flash error status bits stay set until a clear-status command.
// RULE2 - Flash hardware reset clears the whole flash status register.
// RULE3 - Issue read-array before array reads; clear status before program or erase.
// RULE4 - After reset every sector is volatile locked; locked sectors refuse writes.
// RULE5 - Two-cycle unlock or volatile-lock command; sector address in second cycle.
// RULE6 - Sticky-lock command; with write guard low sticky sectors stay read-only.
// RULE7 - With write guard high the sticky lock is ignored.
// RULE8 - Only reset or power cycle clears a sticky lock.
// RULE9 - Low program voltage refuses every erase and program.
// RULE10 - Identification read at sector offset 2 returns lock state on bits 1:0.
// RULE11 - Erase suspend halts erase within 15 us; new erases refused meanwhile.
// RULE12 - Only listed commands are accepted while erase is suspended.
// RULE13 - Program suspend halts programming within 20 us; other words readable.
// RULE14 - Suspends share one code, resumes share another.
// RULE15 - 128-bit protection register; user half programmable until locked.
// RULE16 - Lock user half with a two-cycle command, bit 1 zero in second cycle.
// RULE17 - User-half lock query: bit 1 zero means locked.
// RULE18 - Protection register read after identification entry; read-array to leave.
// RULE19 - Writing 98h enters query mode; read-array leaves it.
// RULE20 - No program cycle with output enable low, select high or write strobe high.
// RULE21 - Programming blocked for a power-on timeout of 10 ms.
// RULE22 - Any word address inside a sector names that sector.
// RULE23 - Writes to locked sectors set the lock-violation bit and abort.
module flash_cmd_ctl #(
  parameter int unsigned POR_CYCLES = flash_ctl_pkg::POR_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Flash pins
  output logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_wp_n,
  output logic flash_vpp_en
);
  typedef enum logic [1:0] {M_IDLE, M_STEP, M_WAIT} seq_state_t;

  flash_bus_if fbus ();

  seq_state_t state_ff;
  flash_ctl_pkg::op_t op_ff;
  logic [1:0] idx_ff;
  logic [20:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [2:0] pins_ff;
  logic done_ff;
  logic refused_ff;
  logic otp_locked_ff;
  logic [1:0] lock_state_ff;
  logic [flash_ctl_pkg::POR_W-1:0] por_cnt_ff;
  logic req_ff;
  logic wr_ff;
  logic [20:0] req_addr_ff;
  logic [15:0] req_data_ff;
  logic [7:0] dp_addr_ff;
  logic dp_write_ff;
  logic [31:0] hrdata_ff;

  // Sequence of flash bus cycles for each operation.
  function automatic flash_ctl_pkg::step_t step_f(input flash_ctl_pkg::op_t op,
                                                 input logic [1:0] idx);
    flash_ctl_pkg::step_t s;
    s = '{flash_ctl_pkg::K_END, flash_ctl_pkg::A_USER, 16'h0000};
    unique case (op)
      flash_ctl_pkg::OP_READ: // [RULE3]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_READ_ARRAY};
        else if (idx == 2'd1) s.kind = flash_ctl_pkg::K_READ;
      flash_ctl_pkg::OP_CLEAR:
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_CLEAR_STATUS};
      flash_ctl_pkg::OP_ERASE, flash_ctl_pkg::OP_PROGRAM: // [RULE3]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_CLEAR_STATUS};
        else if (idx == 2'd1) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                                    (op == flash_ctl_pkg::OP_ERASE) ?
                                    flash_ctl_pkg::FC_ERASE_SETUP : flash_ctl_pkg::FC_PROGRAM};
        else if (idx == 2'd2) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                                    (op == flash_ctl_pkg::OP_ERASE) ?
                                    flash_ctl_pkg::FC_CONFIRM : wdata_ff}; // [RULE22]
      flash_ctl_pkg::OP_SUSPEND, flash_ctl_pkg::OP_RESUME: // [RULE11] [RULE13] [RULE14]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               (op == flash_ctl_pkg::OP_SUSPEND) ?
                               flash_ctl_pkg::FC_SUSPEND : flash_ctl_pkg::FC_CONFIRM};
      flash_ctl_pkg::OP_ID_ENTRY, flash_ctl_pkg::OP_CFI: // [RULE19]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               (op == flash_ctl_pkg::OP_CFI) ?
                               flash_ctl_pkg::FC_CFI : flash_ctl_pkg::FC_ID_ENTRY};
      flash_ctl_pkg::OP_SOFTLOCK, flash_ctl_pkg::OP_HARDLOCK, flash_ctl_pkg::OP_UNLOCK:
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_LOCK_SETUP};
        else if (idx == 2'd1) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                                    (op == flash_ctl_pkg::OP_SOFTLOCK) ? flash_ctl_pkg::FC_SOFTLOCK :
                                    (op == flash_ctl_pkg::OP_HARDLOCK) ? flash_ctl_pkg::FC_HARDLOCK :
                                    flash_ctl_pkg::FC_CONFIRM}; // [RULE5] [RULE6]
      flash_ctl_pkg::OP_READ_STATUS:
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_READ_STATUS};
        else if (idx == 2'd1) s.kind = flash_ctl_pkg::K_READ;
      flash_ctl_pkg::OP_PROT_PROGRAM, flash_ctl_pkg::OP_PROT_LOCK: // [RULE15]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_PROT_SETUP};
        else if (idx == 2'd1 && op == flash_ctl_pkg::OP_PROT_LOCK)
          s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_PROT,
                flash_ctl_pkg::FC_PROT_LOCK_DATA}; // [RULE16]
        else if (idx == 2'd1) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER, wdata_ff};
      flash_ctl_pkg::OP_PROT_QUERY, flash_ctl_pkg::OP_LOCK_QUERY: // [RULE18]
        if (idx == 2'd0) s = '{flash_ctl_pkg::K_WRITE, flash_ctl_pkg::A_USER,
                               flash_ctl_pkg::FC_ID_ENTRY};
        else if (idx == 2'd1) s = '{flash_ctl_pkg::K_READ,
                                    (op == flash_ctl_pkg::OP_PROT_QUERY) ?
                                    flash_ctl_pkg::A_PROT : flash_ctl_pkg::A_LOCK, 16'h0000};
    endcase
    return s;
  endfunction : step_f

  flash_ctl_pkg::step_t cur_step;
  logic [20:0] step_addr;
  logic ap_valid;
  logic wr_cmd;
  logic wr_status;
  logic por_busy;
  logic start_ok;
  logic read_back;
  logic [31:0] rd_mux;

  assign cur_step = step_f(op_ff, idx_ff);
  assign step_addr = (cur_step.asel == flash_ctl_pkg::A_PROT) ? flash_ctl_pkg::PROT_LOCK_ADDR :
                     (cur_step.asel == flash_ctl_pkg::A_LOCK) ?
                     (addr_ff | flash_ctl_pkg::LOCK_STATUS_OFS) : addr_ff; // [RULE10] [RULE22]
  assign ap_valid = hsel && htrans[1] && hready;
  assign wr_cmd = dp_write_ff && (dp_addr_ff == flash_ctl_pkg::REG_CMD);
  assign wr_status = dp_write_ff && (dp_addr_ff == flash_ctl_pkg::REG_STATUS);
  assign por_busy = (por_cnt_ff != '0); // [RULE21]
  assign start_ok = wr_cmd && (state_ff == M_IDLE) && !por_busy && !pins_ff[flash_ctl_pkg::PIN_RST];
  assign read_back = (state_ff == M_WAIT) && fbus.ack && !wr_ff;
  assign rd_mux = (haddr[7:0] == flash_ctl_pkg::REG_ADDR) ? {11'h000, addr_ff} :
                  (haddr[7:0] == flash_ctl_pkg::REG_WDATA) ? {16'h0000, wdata_ff} :
                  (haddr[7:0] == flash_ctl_pkg::REG_CMD) ? {28'h0000000, op_ff} :
                  (haddr[7:0] == flash_ctl_pkg::REG_RDATA) ? {16'h0000, rdata_ff} :
                  (haddr[7:0] == flash_ctl_pkg::REG_STATUS) ?
                  {26'h0000000, lock_state_ff, otp_locked_ff, refused_ff, done_ff,
                   (state_ff != M_IDLE) || por_busy} :
                  (haddr[7:0] == flash_ctl_pkg::REG_PINS) ? {29'h00000000, pins_ff} : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign fbus.req = req_ff;
  assign fbus.wr = wr_ff;
  assign fbus.addr = req_addr_ff;
  assign fbus.wdata = req_data_ff;
  assign flash_reset_n = !pins_ff[flash_ctl_pkg::PIN_RST]; // [RULE2] [RULE4] [RULE8]
  assign flash_wp_n = pins_ff[flash_ctl_pkg::PIN_WP]; // [RULE6] [RULE7]
  assign flash_vpp_en = pins_ff[flash_ctl_pkg::PIN_VPP]; // [RULE9]

  flash_cycle_engine flash_cycle_engine_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(fbus.engine),
    .flash_addr(flash_addr),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  // AHB-Lite address and data phases.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_addr_ff <= 8'h00;
      dp_write_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end
    else
    begin
      if (hready)
        dp_write_ff <= ap_valid && hwrite;
      if (ap_valid)
        dp_addr_ff <= haddr[7:0];
      if (ap_valid && !hwrite)
        hrdata_ff <= rd_mux;
    end
  end

  // Software registers and sticky flags; a set wins over a clear.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_ff <= 21'h000000;
      wdata_ff <= 16'h0000;
      pins_ff <= flash_ctl_pkg::PINS_RST_VAL;
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      por_cnt_ff <= flash_ctl_pkg::POR_W'(POR_CYCLES);
    end
    else
    begin
      if (dp_write_ff && dp_addr_ff == flash_ctl_pkg::REG_ADDR)
        addr_ff <= hwdata[20:0];
      if (dp_write_ff && dp_addr_ff == flash_ctl_pkg::REG_WDATA)
        wdata_ff <= hwdata[15:0];
      if (dp_write_ff && dp_addr_ff == flash_ctl_pkg::REG_PINS)
        pins_ff <= hwdata[2:0];
      done_ff <= (state_ff == M_STEP && cur_step.kind == flash_ctl_pkg::K_END) ||
                 (done_ff && !(wr_status && hwdata[flash_ctl_pkg::ST_DONE]));
      refused_ff <= (wr_cmd && !start_ok) ||
                    (refused_ff && !(wr_status && hwdata[flash_ctl_pkg::ST_REFUSED]));
      if (pins_ff[flash_ctl_pkg::PIN_RST])
        por_cnt_ff <= flash_ctl_pkg::POR_W'(POR_CYCLES); // [RULE21]
      else if (por_busy)
        por_cnt_ff <= por_cnt_ff - 1'b1;
    end
  end

  // Command sequencer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= M_IDLE;
      op_ff <= flash_ctl_pkg::OP_READ;
      idx_ff <= 2'd0;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      req_addr_ff <= 21'h000000;
      req_data_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      otp_locked_ff <= 1'b0;
      lock_state_ff <= 2'b00;
    end
    else
    begin
      req_ff <= 1'b0;
      unique case (state_ff)
        M_IDLE:
          if (start_ok)
          begin
            op_ff <= flash_ctl_pkg::op_t'(hwdata[3:0]);
            idx_ff <= 2'd0;
            state_ff <= M_STEP;
          end
        M_STEP:
          if (cur_step.kind == flash_ctl_pkg::K_END)
            state_ff <= M_IDLE;
          else
          begin
            req_ff <= 1'b1;
            wr_ff <= (cur_step.kind == flash_ctl_pkg::K_WRITE);
            req_addr_ff <= step_addr;
            req_data_ff <= cur_step.data;
            state_ff <= M_WAIT;
          end
        M_WAIT:
          if (fbus.ack)
          begin
            idx_ff <= idx_ff + 2'd1;
            state_ff <= M_STEP;
          end
      endcase
      if (read_back)
      begin
        rdata_ff <= fbus.rdata;
        if (op_ff == flash_ctl_pkg::OP_PROT_QUERY)
          otp_locked_ff <= !fbus.rdata[flash_ctl_pkg::OTP_LOCK_BIT]; // [RULE17]
        if (op_ff == flash_ctl_pkg::OP_LOCK_QUERY)
          lock_state_ff <= fbus.rdata[1:0]; // [RULE10]
      end
    end
  end
endmodule : flash_cmd_ctl

// *** dv/flash_cmd_ctl_monitor.sv ***
// Purpose: Port checks on the flash command controller.
// Assumes: One clock domain; hresetn is active low.
// Notes: Bound to every instance of the controller.
`timescale 1ns/10ps
module flash_cmd_ctl_monitor #(
  parameter int unsigned POR_CYCLES = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Flash pins
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n
);
  logic [31:0] por_ff;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      por_ff <= 32'h0;
    else
      por_ff <= !flash_reset_n ? 32'h0 : por_ff + 32'(por_ff < POR_CYCLES);
  end
  sequence s_strobe;
    (!flash_we_n) [*8] ##1 flash_we_n;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
  a_we_width: assert property ($fell(flash_we_n) |=> s_strobe)
    else $error("write strobe width wrong");
  a_we_gated: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("strobe without select");
  a_we_setup: assert property ($fell(flash_we_n) |-> $past(!flash_ce_n, 2))
    else $error("select setup short");
  a_addr_hold: assert property (!flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address moved under strobe");
  a_por_block: assert property (por_ff < POR_CYCLES |-> flash_we_n)
    else $error("write in power-on lockout");
  a_rst_quiet: assert property (!flash_reset_n |-> flash_we_n)
    else $error("write during flash reset");
  a_read_only: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("drive during read");
  a_reset_exit: assert property ($rose(hresetn) |-> flash_ce_n && flash_oe_n && !flash_dq_oe)
    else $error("pins busy after reset");
endmodule : flash_cmd_ctl_monitor
bind flash_cmd_ctl flash_cmd_ctl_monitor #(.POR_CYCLES(POR_CYCLES)) flash_cmd_ctl_monitor_inst (.*);

// *** dv/flash_dev_model.sv ***
// Purpose: Behavioural flash device with locks, status and protection register.
// Assumes: Sector number is address bits 20:15.
// Notes: Array contents are a pattern of the address; program and erase end at once.
`timescale 1ns/10ps
module flash_dev_model (
  // Flash pins
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic flash_wp_n,
  input wire logic flash_vpp_en,
  output logic [15:0] flash_dq_i
);
  logic [6:0] sr_ff = 7'h0;
  logic [63:0] soft_ff = '1, hard_ff = '0;
  logic otp_ff = 1'b0;
  logic [7:0] pend_ff = 8'h0;
  logic [1:0] mode_ff = 2'h0;
  logic [15:0] rd, hold_ff = 16'h0;
  wire [5:0] sec = flash_addr[20:15];
  wire [7:0] d = flash_dq_o[7:0];
  wire locked = soft_ff[sec] | (hard_ff[sec] & ~flash_wp_n);
  always @(posedge flash_we_n or negedge flash_reset_n)
  begin
    if (!flash_reset_n)
    begin
      sr_ff <= 7'h0;
      soft_ff <= '1;
      hard_ff <= '0;
      pend_ff <= 8'h0;
      mode_ff <= 2'h0;
    end
    else if (!flash_ce_n && flash_oe_n)
    begin
      pend_ff <= 8'h0;
      mode_ff <= 2'h1;
      case (pend_ff)
        8'h60: if (d == 8'h01) soft_ff[sec] <= 1'b1;
          else if (d == 8'h2F) hard_ff[sec] <= 1'b1;
          else if (d == 8'hD0 && !(hard_ff[sec] && !flash_wp_n)) soft_ff[sec] <= 1'b0;
        8'h20, 8'h40: if (!flash_vpp_en) sr_ff[3] <= 1'b1;
          else if (locked) sr_ff[1] <= 1'b1;
        8'hC0: if (flash_addr[7:0] == 8'h80) otp_ff <= otp_ff | ~flash_dq_o[1];
          else if (otp_ff) sr_ff[4] <= 1'b1;
        default:
        begin
          pend_ff <= d;
          mode_ff <= (d == 8'h70) ? 2'h1 : (d == 8'h90) ? 2'h2 : (d == 8'h98) ? 2'h3 : 2'h0;
          if (d == 8'h50) sr_ff <= 7'h0;
        end
      endcase
    end
  end
  always_comb
  begin
    rd = flash_addr[15:0] ^ 16'h5A5A;
    if (mode_ff == 2'h1) rd = {9'h001, sr_ff};
    if (mode_ff == 2'h2) rd = (flash_addr[7:0] == 8'h80) ? {14'h0, ~otp_ff, 1'b0}
      : {14'h0, hard_ff[sec], soft_ff[sec]};
  end
  always @(posedge flash_oe_n) hold_ff <= rd;
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd : ~hold_ff;
endmodule : flash_dev_model

// *** dv/flash_cmd_ctl_tb_top.sv ***
// Purpose: Self-checking bench of the flash command controller with a device model.
// Assumes: A 250 MHz clock and a shortened power-on lockout.
// Notes: Sectors and data offsets are random from a fixed seed.
`timescale 1ns/10ps
module flash_cmd_ctl_tb_top;
  localparam int unsigned POR = 20;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, seed = 32'h00001D1A;
  logic [20:0] base;
  wire hready, hreadyout, hresp, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  wire flash_reset_n, flash_wp_n, flash_vpp_en;
  wire [31:0] hrdata;
  wire [20:0] flash_addr;
  wire [15:0] flash_dq_i, flash_dq_o;
  int num_errors = 0, checks_done = 0, cycles = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  flash_cmd_ctl #(.POR_CYCLES(POR)) flash_cmd_ctl_inst (.*);
  flash_dev_model flash_dev_model_inst (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic op(input logic [3:0] c);
    bus(1'b1, flash_ctl_pkg::REG_CMD, {28'h0, c});
    @(posedge hclk);
    do bus(1'b0, flash_ctl_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
    cmp(rd & 32'h6, 32'h2);
    bus(1'b1, flash_ctl_pkg::REG_STATUS, 32'h6);
  endtask : op
  task automatic lockq(input logic [1:0] e);
    bus(1'b1, flash_ctl_pkg::REG_ADDR, {11'h0, base});
    op(4'hF);
    cmp({30'h0, rd[5:4]}, {30'h0, e});
  endtask : lockq
  task automatic stq(input logic [31:0] e);
    op(4'hA);
    bus(1'b0, flash_ctl_pkg::REG_RDATA, 32'h0);
    cmp(rd & 32'h1A, e);
  endtask : stq
  task automatic prog(input logic [3:0] c, input logic [31:0] e);
    seed = xs(seed);
    bus(1'b1, flash_ctl_pkg::REG_ADDR, {11'h0, base | seed[14:0]});
    bus(1'b1, flash_ctl_pkg::REG_WDATA, xs(seed));
    op(c);
    stq(e);
  endtask : prog
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, flash_ctl_pkg::REG_STATUS, 32'h0);
    cmp(rd & 32'h1, 32'h1);
    bus(1'b1, flash_ctl_pkg::REG_CMD, 32'h3);
    bus(1'b0, flash_ctl_pkg::REG_STATUS, 32'h0);
    cmp(rd & 32'h4, 32'h4);
    bus(1'b1, flash_ctl_pkg::REG_STATUS, 32'h4);
    repeat (POR) @(posedge hclk);
    bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h2);
    for (int k = 0; k < 3; k++)
    begin
      seed = xs(seed);
      base = {k[1:0], seed[3:0], 15'h0};
      lockq(2'b01);
      prog(4'h3, 32'h2);
      op(4'h1);
      stq(32'h0);
      prog(4'h9, 32'h0);
      lockq(2'b00);
      prog(4'h2, 32'h0);
      prog(4'h7, 32'h0);
      prog(4'h8, 32'h0);
      prog(4'h9, 32'h0);
      lockq(2'b11);
      bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h3);
      prog(4'h9, 32'h0);
      lockq(2'b10);
      prog(4'h3, 32'h0);
      bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h1);
      prog(4'h3, 32'h8);
      bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h2);
      $display("sector test done base=%h", base);
    end
    for (int i = 5; i >= 0; i--) op(i[0] ? 4'h5 : (i < 3 ? 4'h4 : 4'hE));
    op(4'h6);
    op(4'h0);
    bus(1'b0, flash_ctl_pkg::REG_RDATA, 32'h0);
    cmp(rd, {16'h0, {base[15], seed[14:0]} ^ 16'h5A5A});
    op(4'hD);
    cmp(rd & 32'h8, 32'h0);
    op(4'hC);
    op(4'hD);
    cmp(rd & 32'h8, 32'h8);
    base = 21'h000085;
    prog(4'hB, 32'h18);
    $display("protection test done");
    bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h6);
    bus(1'b1, flash_ctl_pkg::REG_PINS, 32'h2);
    repeat (POR + 4) @(posedge hclk);
    stq(32'h0);
    lockq(2'b01);
    $display("flash reset test done");
    end_sim();
  end
endmodule : flash_cmd_ctl_tb_top
